// file: design/sfd_cmd_if.sv
// carrier between the decoder core and the cache flush starter
// assumes both ends run on pclk
`timescale 1ns/1ps
`default_nettype none
interface sfd_cmd_if;
	logic flush_req; // pulse: begin flushing the write cache
	logic flush_started; // pulse: the flush sequence has begun
	logic flush_busy; // level: flush running toward memory
	modport core (output flush_req, input flush_started, input flush_busy);
	modport flusher (input flush_req, output flush_started, output flush_busy);
endinterface
`default_nettype wire

// file: design/sfd_decoder.sv
// set-features command decoder behind an apb task file
// assumes an apb master on pclk; flush_done is a level from another domain
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder
	import sfd_pkg::*;
#(
	parameter logic DMA_CAPABLE = 1'b1,
	parameter logic CACHE_PRESENT = 1'b1,
	parameter logic [2:0] PIO_MAX = 3'h6,
	parameter logic [2:0] MDMA_MAX = 3'h4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic flush_done,
	output logic byte_wide_mode,
	output logic sixteen_bit_io_indicator,
	output logic write_cache_on,
	output logic [2:0] pio_mode,
	output logic [2:0] mdma_mode,
	output logic lookahead_on,
	output logic command_busy,
	output logic command_error
);
	import sfd_pkg::*;

	// ************************************************************
	// declarations
	// ************************************************************
	// flush start handshake with the cache side
	sfd_cmd_if cmd_bus(); // link to the flush starter
	sfd_settings_type settings; // live feature settings
	sfd_settings_type next_settings; // settings after the current subcommand
	logic [7:0] feature_select; // subcommand code
	logic [7:0] transfer_count; // parameter byte
	logic [7:0] sector_number;
	logic [7:0] cylinder_low;
	logic [7:0] cylinder_high;
	logic [7:0] drive_head_select;
	logic [7:0] error_code; // last command's error byte
	logic flush_sync_a; // first synchroniser stage, read only by the second
	logic flush_sync_b; // flush_done in pclk domain
	logic go; // pulse: set-features written
	logic next_abort; // subcommand rejected
	logic next_needs_flush; // subcommand turns the cache off, whether or not it was on
	logic access; // apb access phase
	logic [9:0] word_index; // register index from the byte address
	logic soft_reset_req; // pulse from the control register
	logic unmapped; // address hits no register

	// ready for commands, or waiting on the flush start
	typedef enum logic [1:0] {
		SFD_IDLE,
		SFD_WAIT_FLUSH
	} sfd_state_type;
	sfd_state_type state;

	// access phase of an apb transfer
	assign access = psel && penable;
	// byte address to word index; low bits must be zero
	assign word_index = paddr[11:2];
	// index zero, the gap above control and misaligned words are refused
	assign unmapped = word_index > 10'(SFD_IDX_CONTROL) || word_index == 10'h0
		|| paddr[1:0] != 2'h0;

	// ************************************************************
	// flush starter
	// ************************************************************
	sfd_flush_starter u_flush (
		.pclk(pclk),
		.presetn(presetn),
		.flush_done(flush_sync_b),
		.cmd(cmd_bus.flusher)
	);

	// two-stage synchroniser for the memory side's done level
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_sync_a <= 1'b0;
			flush_sync_b <= 1'b0;
		end else begin
			// first stage may go metastable; only stage two is read
			flush_sync_a <= flush_done;
			flush_sync_b <= flush_sync_a;
		end
	end

	// ************************************************************
	// apb: single wait cycle, so every answer comes at the second access edge
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			// pready rises one cycle into the access phase, then drops
			pready <= access && !pready;
			// error rides on the same pulse as ready
			pslverr <= access && !pready && unmapped;
		end
	end

	// read data, registered while the answer is being prepared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (access && !pready && !pwrite) begin
			// only reads load the register, writes leave it alone
			unique case (word_index)
				10'(SFD_IDX_COUNT): prdata <= {24'h0, transfer_count};
				10'(SFD_IDX_SECTOR): prdata <= {24'h0, sector_number};
				10'(SFD_IDX_CYL_LOW): prdata <= {24'h0, cylinder_low};
				10'(SFD_IDX_CYL_HIGH): prdata <= {24'h0, cylinder_high};
				10'(SFD_IDX_DRIVE_HEAD): prdata <= {24'h0, drive_head_select};
				// status: busy, error flag, error code
				// bit 10 shows a flush still running toward memory
				10'(SFD_IDX_STATUS): prdata <= {21'h0, cmd_bus.flush_busy, command_busy,
					command_error, error_code};
				// settings snapshot, msb first, upper bits zero
				10'(SFD_IDX_SETTINGS): prdata <= {10'h0, settings};
				default: prdata <= 32'h0; // write-only and unmapped read zero
			endcase
		end
	end

	// ************************************************************
	// task file registers
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// task file clears on power-up reset only
			feature_select <= 8'h0;
			transfer_count <= 8'h0;
			sector_number <= 8'h0;
			cylinder_low <= 8'h0;
			cylinder_high <= 8'h0;
			drive_head_select <= 8'h0;
		end else if (access && pready && pwrite && !command_busy && !unmapped) begin
			// task file is frozen while a command is busy
			unique case (word_index)
				10'(SFD_IDX_FEATURE): feature_select <= pwdata[7:0];
				10'(SFD_IDX_COUNT): transfer_count <= pwdata[7:0];
				10'(SFD_IDX_SECTOR): sector_number <= pwdata[7:0];
				10'(SFD_IDX_CYL_LOW): cylinder_low <= pwdata[7:0];
				10'(SFD_IDX_CYL_HIGH): cylinder_high <= pwdata[7:0];
				10'(SFD_IDX_DRIVE_HEAD): drive_head_select <= pwdata[7:0];
				// command and control are handled by the strobe logic
				default: ;
			endcase
		end
	end

	// command strobe and soft reset request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			go <= 1'b0;
			soft_reset_req <= 1'b0;
		end else begin
			// refused accesses never reach the command logic
			go <= access && pready && pwrite && !command_busy && !unmapped
				&& word_index == 10'(SFD_IDX_COMMAND)
				&& pwdata[7:0] == SFD_CMD_SET_FEATURES;
			// soft reset is honoured even while a flush start is pending
			soft_reset_req <= access && pready && pwrite && !unmapped
				&& word_index == 10'(SFD_IDX_CONTROL) && pwdata[0];
		end
	end

	// ************************************************************
	// subcommand decode
	// ************************************************************
	always_comb begin
		// start from the live settings, no abort, no flush
		next_settings = settings;
		next_abort = 1'b0;
		next_needs_flush = 1'b0;
		// one item per supported subcommand, the three no-op codes sharing one
		unique case (feature_select)
			SFD_SUB_BYTE_ON: next_settings.byte_wide = 1'b1;
			SFD_SUB_BYTE_OFF: next_settings.byte_wide = 1'b0;
			// without a cache both cache codes abort
			SFD_SUB_CACHE_ON: begin
				if (CACHE_PRESENT) next_settings.write_cache = 1'b1;
				else next_abort = 1'b1;
			end
			SFD_SUB_CACHE_OFF: begin
				if (CACHE_PRESENT) begin
					next_settings.write_cache = 1'b0;
					next_needs_flush = 1'b1;
				end else begin
					next_abort = 1'b1;
				end
			end
			SFD_SUB_XFER_MODE: begin
				// type in the upper five bits, mode in the low three
				if ((transfer_count[7:3] == SFD_TYPE_PIO_DEFAULT
					|| transfer_count[7:3] == SFD_TYPE_PIO_FLOW)
					&& transfer_count[2:0] <= PIO_MAX) begin
					next_settings.pio_mode = transfer_count[2:0];
				end else if (DMA_CAPABLE && transfer_count[7:3] == SFD_TYPE_MDMA
					&& transfer_count[2:0] <= MDMA_MAX) begin
					next_settings.mdma_mode = transfer_count[2:0];
				end else begin
					next_abort = 1'b1; // bad type or mode keeps the old selection
				end
			end
			// advanced power management
			SFD_SUB_APM_ON: next_settings.apm = 1'b1;
			SFD_SUB_APM_OFF: next_settings.apm = 1'b0;
			// extended power, which may be withdrawn later
			SFD_SUB_EXT_PWR_ON: next_settings.ext_power = 1'b1;
			SFD_SUB_EXT_PWR_OFF: next_settings.ext_power = 1'b0;
			// power level 1 command permission
			SFD_SUB_PL1_ON: next_settings.power_level1 = 1'b1;
			SFD_SUB_PL1_OFF: next_settings.power_level1 = 1'b0;
			// ecc length carried by long commands
			SFD_SUB_ECC_VENDOR: next_settings.ecc_vendor = 1'b1;
			SFD_SUB_ECC_FOUR: next_settings.ecc_vendor = 1'b0;
			// read look-ahead
			SFD_SUB_LOOKAHEAD_OFF: next_settings.lookahead = 1'b0;
			SFD_SUB_LOOKAHEAD_ON: next_settings.lookahead = 1'b1;
			// what a soft reset does to the settings
			SFD_SUB_KEEP_SETTINGS: next_settings.keep_on_soft_reset = 1'b1;
			SFD_SUB_LOAD_DEFAULTS: next_settings.keep_on_soft_reset = 1'b0;
			// kept only so that older hosts see no error
			SFD_SUB_NOP_A, SFD_SUB_NOP_B, SFD_SUB_NOP_C: ;
			// host current source capability byte, stored as written
			SFD_SUB_CURRENT: next_settings.current_cap = transfer_count;
			default: next_abort = 1'b1;
		endcase
		// a rejected subcommand leaves every setting alone
		if (next_abort) next_settings = settings;
	end

	// ************************************************************
	// settings store with power-up defaults
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// power-up defaults; cache follows whether one is fitted
			settings <= '{byte_wide: 1'b0, write_cache: CACHE_PRESENT, apm: 1'b0,
				ext_power: 1'b0, power_level1: 1'b1, ecc_vendor: 1'b0,
				lookahead: 1'b1, keep_on_soft_reset: 1'b0, pio_mode: SFD_PIO_RESET,
				mdma_mode: SFD_MDMA_RESET, current_cap: SFD_CURRENT_RESET};
		end else if (go) begin
			settings <= next_settings;
		end else if (soft_reset_req && !settings.keep_on_soft_reset) begin
			// soft reset reloads defaults unless told to keep them
			settings <= '{byte_wide: 1'b0, write_cache: CACHE_PRESENT, apm: 1'b0,
				ext_power: 1'b0, power_level1: 1'b1, ecc_vendor: 1'b0,
				lookahead: 1'b1, keep_on_soft_reset: 1'b0, pio_mode: SFD_PIO_RESET,
				mdma_mode: SFD_MDMA_RESET, current_cap: SFD_CURRENT_RESET};
		end
	end

	// ************************************************************
	// completion sequencing
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= SFD_IDLE;
			command_busy <= 1'b0;
			command_error <= 1'b0;
			error_code <= 8'h0;
			cmd_bus.flush_req <= 1'b0;
		end else begin
			// flush request is a single-cycle pulse
			cmd_bus.flush_req <= 1'b0;
			unique case (state)
				SFD_IDLE: begin
					if (go) begin
						// error status follows every set-features command
						command_error <= next_abort;
						error_code <= next_abort ? SFD_ERR_ABORT : 8'h0;
						if (next_needs_flush && !next_abort) begin
							// completion held back until the flush has begun
							cmd_bus.flush_req <= 1'b1;
							command_busy <= 1'b1;
							state <= SFD_WAIT_FLUSH;
						end
					end
				end
				SFD_WAIT_FLUSH: begin
					// completion waits for the start only, not the whole flush
					if (cmd_bus.flush_started) begin
						command_busy <= 1'b0;
						state <= SFD_IDLE;
					end
				end
			endcase
		end
	end

	// ************************************************************
	// outputs from flip-flops
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// all outputs low while reset is held
			byte_wide_mode <= 1'b0;
			sixteen_bit_io_indicator <= 1'b0;
			write_cache_on <= 1'b0;
			pio_mode <= SFD_PIO_RESET;
			mdma_mode <= SFD_MDMA_RESET;
			lookahead_on <= 1'b0;
		end else begin
			// one cycle behind the settings so every output is a flop
			byte_wide_mode <= settings.byte_wide;
			// indicator stays low for data accesses in byte-wide mode
			sixteen_bit_io_indicator <= !settings.byte_wide;
			write_cache_on <= settings.write_cache;
			// selections are always legal, so one mode of each kind stands
			pio_mode <= settings.pio_mode;
			mdma_mode <= settings.mdma_mode;
			lookahead_on <= settings.lookahead;
		end
	end
endmodule
`default_nettype wire

// file: design/sfd_flush_starter.sv
// write cache flush starter: acknowledges the start of a flush
// assumes flush_done comes from the memory side through a synchroniser upstream
`timescale 1ns/1ps
`default_nettype none
module sfd_flush_starter
	import sfd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic flush_done,
	sfd_cmd_if.flusher cmd
);
	// counts the short delay before the flush is reported as started
	logic [1:0] start_count;
	// ************************************************************
	// start sequence and busy flag
	// ************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_count <= 2'h0;
			cmd.flush_started <= 1'b0;
			cmd.flush_busy <= 1'b0;
		end else begin
			cmd.flush_started <= 1'b0;
			// clear first so a start in the same cycle wins
			if (flush_done && cmd.flush_busy) begin
				cmd.flush_busy <= 1'b0;
			end
			if (cmd.flush_req && start_count == 2'h0) begin
				start_count <= 2'(SFD_FLUSH_START_CYCLES);
			end else if (start_count != 2'h0) begin
				start_count <= start_count - 2'h1;
				// report start on the last count, busy from then on
				if (start_count == 2'h1) begin
					cmd.flush_started <= 1'b1;
					cmd.flush_busy <= 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: design/sfd_pkg.sv
// constants for the set-features command decoder
// assumes an apb master on a 20 MHz clock reaching the task file
package sfd_pkg;
	// ************************************************************
	// task file register indices (byte address is four times these)
	// ************************************************************
	localparam logic [2:0] SFD_IDX_FEATURE = 3'h1;
	localparam logic [2:0] SFD_IDX_COUNT = 3'h2;
	localparam logic [2:0] SFD_IDX_SECTOR = 3'h3;
	localparam logic [2:0] SFD_IDX_CYL_LOW = 3'h4;
	localparam logic [2:0] SFD_IDX_CYL_HIGH = 3'h5;
	localparam logic [2:0] SFD_IDX_DRIVE_HEAD = 3'h6;
	localparam logic [2:0] SFD_IDX_COMMAND = 3'h7;
	// status, settings and control registers of our own
	localparam logic [3:0] SFD_IDX_STATUS = 4'h8;
	localparam logic [3:0] SFD_IDX_SETTINGS = 4'h9;
	localparam logic [3:0] SFD_IDX_CONTROL = 4'ha;
	// ************************************************************
	// command and subcommand codes
	// ************************************************************
	localparam logic [7:0] SFD_CMD_SET_FEATURES = 8'hef;
	localparam logic [7:0] SFD_SUB_BYTE_ON = 8'h01;
	localparam logic [7:0] SFD_SUB_CACHE_ON = 8'h02;
	localparam logic [7:0] SFD_SUB_XFER_MODE = 8'h03;
	localparam logic [7:0] SFD_SUB_APM_ON = 8'h05;
	localparam logic [7:0] SFD_SUB_EXT_PWR_ON = 8'h09;
	localparam logic [7:0] SFD_SUB_PL1_ON = 8'h0a;
	localparam logic [7:0] SFD_SUB_ECC_VENDOR = 8'h44;
	localparam logic [7:0] SFD_SUB_LOOKAHEAD_OFF = 8'h55;
	localparam logic [7:0] SFD_SUB_KEEP_SETTINGS = 8'h66;
	localparam logic [7:0] SFD_SUB_NOP_A = 8'h69;
	localparam logic [7:0] SFD_SUB_BYTE_OFF = 8'h81;
	localparam logic [7:0] SFD_SUB_CACHE_OFF = 8'h82;
	localparam logic [7:0] SFD_SUB_APM_OFF = 8'h85;
	localparam logic [7:0] SFD_SUB_EXT_PWR_OFF = 8'h89;
	localparam logic [7:0] SFD_SUB_PL1_OFF = 8'h8a;
	localparam logic [7:0] SFD_SUB_NOP_B = 8'h96;
	localparam logic [7:0] SFD_SUB_NOP_C = 8'h97;
	localparam logic [7:0] SFD_SUB_CURRENT = 8'h9a;
	localparam logic [7:0] SFD_SUB_LOOKAHEAD_ON = 8'haa;
	localparam logic [7:0] SFD_SUB_ECC_FOUR = 8'hbb;
	localparam logic [7:0] SFD_SUB_LOAD_DEFAULTS = 8'hcc;
	// transfer type field (upper five bits of the count register)
	localparam logic [4:0] SFD_TYPE_PIO_DEFAULT = 5'h00;
	localparam logic [4:0] SFD_TYPE_PIO_FLOW = 5'h01;
	localparam logic [4:0] SFD_TYPE_MDMA = 5'h04;
	// ************************************************************
	// values after reset and timing
	// ************************************************************
	localparam logic [2:0] SFD_PIO_RESET = 3'h0;
	localparam logic [2:0] SFD_MDMA_RESET = 3'h0;
	localparam logic [7:0] SFD_CURRENT_RESET = 8'h00;
	localparam logic [7:0] SFD_ERR_ABORT = 8'h04;
	localparam int SFD_FLUSH_START_CYCLES = 2;
	// settings bundle kept by the decoder
	typedef struct packed {
		logic byte_wide;
		logic write_cache;
		logic apm;
		logic ext_power;
		logic power_level1;
		logic ecc_vendor;
		logic lookahead;
		logic keep_on_soft_reset;
		logic [2:0] pio_mode;
		logic [2:0] mdma_mode;
		logic [7:0] current_cap;
	} sfd_settings_type;
endpackage

// file: tb/set_features_decoder_test.sv
// self-checking bench for the set-features decoder
// assumes the host model drives apb and a small memory model answers flushes
`timescale 1ns/1ps
`default_nettype none
module set_features_decoder_test;
	import sfd_pkg::*;
	// **********
	// signals and expected state
	// **********
	localparam logic [2:0] PIO_MAX = 3'h6; // highest pio mode offered
	localparam logic [2:0] MDMA_MAX = 3'h4; // highest multiword dma mode offered
	localparam sfd_settings_type DEF = sfd_settings_type'({8'h4a, 14'h0}); // power-up values
	// eight set codes, their eight clear codes, then the rest
	localparam logic [7:0] CODES [21] = '{8'h01, 8'h02, 8'h05, 8'h09, 8'h0a, 8'h44, 8'haa, 8'h66,
		8'h81, 8'h82, 8'h85, 8'h89, 8'h8a, 8'hbb, 8'h55, 8'hcc, 8'h03, 8'h69, 8'h96, 8'h97, 8'h9a};
	localparam logic [7:0] MODES [7] = '{8'h06, 8'h07, 8'h0e, 8'h24, 8'h25, 8'h10, 8'h1b};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic flush_done = 1'b0; // memory side done level
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [31:0] seed = 32'he7fd; // fixed start keeps runs repeatable
	logic byte_wide_mode, sixteen_bit_io_indicator, write_cache_on, lookahead_on;
	logic command_busy, command_error;
	logic [2:0] pio_mode, mdma_mode;
	logic [1:0] fl_sr = 2'h0; // memory side delay line
	int num_errors = 0;
	int n_compared = 0;
	sfd_settings_type exp_s; // settings the design should hold
	sfd_decoder #(.PIO_MAX(PIO_MAX), .MDMA_MAX(MDMA_MAX)) dut_u (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .flush_done,
		.byte_wide_mode, .sixteen_bit_io_indicator, .write_cache_on, .pio_mode, .mdma_mode,
		.lookahead_on, .command_busy, .command_error);
	sfd_host_model host_u (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);
	// 20 MHz clock
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	// memory side reports the flush complete a few cycles after it is asked
	always @(posedge pclk) begin
		fl_sr <= {fl_sr[0], command_busy};
		flush_done <= fl_sr[1];
	end
	// **********
	// helpers
	// **********
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// settings after one subcommand; an unknown code leaves all as it was
	function automatic sfd_settings_type nxt(input sfd_settings_type s, input logic [7:0] f,
		input logic [7:0] c, output logic err);
		sfd_settings_type r;
		r = s;
		err = 1'b1;
		for (int k = 0; k < 21; k++) begin
			if (f == CODES[k]) err = 1'b0;
		end
		for (int k = 0; k < 8; k++) begin
			if (f == CODES[k]) r[21 - k] = 1'b1;
			if (f == CODES[k + 8]) r[21 - k] = 1'b0;
		end
		if (f == 8'h9a) r.current_cap = c;
		if (f == 8'h03 && c[7:3] <= 5'h01 && c[2:0] <= PIO_MAX) r.pio_mode = c[2:0];
		else if (f == 8'h03 && c[7:3] == 5'h04 && c[2:0] <= MDMA_MAX) r.mdma_mode = c[2:0];
		else if (f == 8'h03) err = 1'b1;
		return err ? s : r;
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		host_u.xfer(1'b1, a, {24'h0, d}, q, e);
	endtask
	// outputs settle two cycles after the write edge, so wait three
	task automatic check_all(input logic ce, input logic err);
		logic [31:0] q;
		logic e;
		repeat (3) @(posedge pclk);
		host_u.xfer(1'b0, 12'h024, 32'h0, q, e);
		chk("settings", q[21:0], exp_s);
		if (ce) begin
			host_u.xfer(1'b0, 12'h020, 32'h0, q, e);
			chk("abort flag", q[8], err);
			chk("error port", command_error, err);
			if (err) chk("abort code", q[7:0], 8'h04);
		end
		chk("byte lanes", byte_wide_mode, exp_s.byte_wide);
		chk("sixteen bit", sixteen_bit_io_indicator, !exp_s.byte_wide);
		chk("cache", write_cache_on, exp_s.write_cache);
		chk("pio", pio_mode, exp_s.pio_mode);
		chk("mdma", mdma_mode, exp_s.mdma_mode);
		chk("look ahead", lookahead_on, exp_s.lookahead);
	endtask
	task automatic soft_rst();
		wr(12'h028, 8'h01);
		if (!exp_s.keep_on_soft_reset) exp_s = DEF;
		check_all(1'b0, 1'b0);
	endtask
	// feature, count, then command; waits out any flush start
	task automatic run_cmd(input logic [7:0] f, input logic [7:0] c);
		logic err, seen;
		int n;
		sfd_settings_type s2;
		s2 = nxt(exp_s, f, c, err);
		wr(12'h004, f);
		wr(12'h008, c);
		wr(12'h01c, 8'hef);
		seen = 1'b0;
		n = 0;
		do begin
			@(posedge pclk);
			seen = seen | command_busy;
			n++;
		end while ((n < 4 || command_busy !== 1'b0) && n < 40);
		if (f == 8'h82 && exp_s.write_cache) chk("flush started", seen, 1'b1);
		exp_s = s2;
		check_all(1'b1, err);
	endtask
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// watchdog, far beyond the few thousand cycles the run needs
	initial begin
		repeat (30000) @(posedge pclk);
		num_errors++;
		print_verdict();
	end
	// **********
	// main sequence
	// **********
	initial begin
		logic [31:0] r, q;
		logic e;
		presetn = 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		exp_s = DEF;
		check_all(1'b0, 1'b0);
		foreach (CODES[k]) run_cmd(CODES[k], 8'h0c);
		foreach (MODES[k]) run_cmd(8'h03, MODES[k]);
		soft_rst();
		run_cmd(8'h66, 8'h00);
		run_cmd(8'h55, 8'h00);
		soft_rst();
		// refused places must change nothing
		host_u.xfer(1'b1, 12'h005, 32'h82, q, e);
		chk("misaligned feature", e, 1'b1);
		host_u.xfer(1'b1, 12'h01e, 32'hef, q, e);
		chk("misaligned", e, 1'b1);
		host_u.xfer(1'b0, 12'h02c, 32'h0, q, e);
		chk("unmapped", e, 1'b1);
		host_u.xfer(1'b1, 12'h000, 32'h82, q, e);
		chk("index zero", e, 1'b1);
		check_all(1'b0, 1'b0);
		for (int i = 2; i < 7; i++) begin
			r = xs();
			host_u.xfer(1'b1, 12'(i * 4), {24'h0, r[7:0]}, q, e);
			host_u.xfer(1'b0, 12'(i * 4), 32'h0, q, e);
			chk("task file", q, {24'h0, r[7:0]});
		end
		// random codes and counts, with soft resets mixed in
		for (int i = 0; i < 100; i++) begin
			r = xs();
			if (r[2:0] == 3'h0) begin
				soft_rst();
			end else begin
				run_cmd(r[3] ? CODES[r[12:8] % 21] : r[23:16],
					r[5] ? {(r[6] ? 5'h04 : {4'h0, r[7]}), r[10:8]} : r[31:24]);
			end
		end
		print_verdict();
	end
endmodule
bind sfd_decoder sfd_decoder_asserts #(.PIO_MAX(PIO_MAX), .MDMA_MAX(MDMA_MAX)) chk_u (.pclk,
	.presetn, .psel, .penable, .pwrite, .paddr, .pready, .pslverr, .byte_wide_mode,
	.sixteen_bit_io_indicator, .write_cache_on, .pio_mode, .mdma_mode, .command_busy,
	.command_error);
`default_nettype wire

// file: tb/sfd_decoder_asserts.sv
// port checks for the set-features decoder
// assumes a bind onto sfd_decoder and one pclk domain
`timescale 1ns/1ps
`default_nettype none
module sfd_decoder_asserts #(
	parameter logic [2:0] PIO_MAX = 3'h6,
	parameter logic [2:0] MDMA_MAX = 3'h4
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic byte_wide_mode,
	input wire logic sixteen_bit_io_indicator,
	input wire logic write_cache_on,
	input wire logic [2:0] pio_mode,
	input wire logic [2:0] mdma_mode,
	input wire logic command_busy,
	input wire logic command_error
);
	// **********
	// cycles since a command or control write
	// **********
	logic [3:0] since; // saturates so a long idle never wraps into the window
	// counts from each write that may legally move a setting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= 4'hf;
		end else if (psel && penable && pwrite && (paddr == 12'h01c || paddr == 12'h028)) begin
			since <= 4'h0;
		end else if (since != 4'hf) begin
			since <= since + 4'h1;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// **********
	// properties
	// **********
	AST_ONE_WAIT: assert property (psel && penable && !pready |=> pready)
		else $error("apb answer not after one wait state");
	AST_CHANGE_CAUSE: assert property ($past(presetn, 3) && ($changed(pio_mode) ||
		$changed(mdma_mode) || $changed(write_cache_on)) |-> since < 4'hc)
		else $error("setting moved without a command");
	AST_BYTE_LANES: assert property (byte_wide_mode |-> !sixteen_bit_io_indicator)
		else $error("sixteen-bit indicator up in byte mode");
	AST_WORD_LANES: assert property ($past(presetn) && !byte_wide_mode |-> sixteen_bit_io_indicator)
		else $error("sixteen-bit indicator down in word mode");
	AST_FLUSH_START: assert property (command_busy |-> ##[1:16] !command_busy)
		else $error("flush start never acknowledged");
	AST_PIO_ONE: assert property (pio_mode <= PIO_MAX)
		else $error("pio mode out of range");
	AST_MDMA_ONE: assert property (mdma_mode <= MDMA_MAX)
		else $error("dma mode out of range");
	AST_BAD_ALIGN: assert property (psel && penable && !pready && paddr[1:0] != 2'h0
		|=> pready && pslverr)
		else $error("misaligned access not refused");
	AST_ABORT_KEEP: assert property ($rose(command_error) |-> ($stable(pio_mode) &&
		$stable(mdma_mode) && $stable(write_cache_on) && $stable(byte_wide_mode)) [*3])
		else $error("aborted command moved a setting");
endmodule
`default_nettype wire

// file: tb/sfd_host_model.sv
// apb host model standing in for the task-file controller
// assumes the bench calls xfer and waits for it to return
`timescale 1ns/1ps
`default_nettype none
module sfd_host_model (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// **********
	// bus idle from time zero
	// **********
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
	end
	// one transfer, request held until pready is sampled high; only register
	// moves are made, never dma data, so byte-wide mode never meets dma
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// waits as long as the slave needs; the bench watchdog ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule
`default_nettype wire
